/* dv/stc_pullup.sv */
// Pull-up resistor on the open-drain fault pin.
`timescale 1ns/1ps
module stc_pullup (
  input wire logic i_drive,
  input wire logic i_level,
  output logic o_wire
);
  // Released pin floats to the resistor's high level
  assign o_wire = i_drive ? i_level : 1'b1;
endmodule

/* dv/stc_service_timer_monitor.sv */
// Port checker for the service timer and clock monitor.
`timescale 1ns/1ps
module stc_service_timer_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_svc_wr,
  input wire logic [7:0] o_svc_rdata,
  input wire logic o_port_g_bit1,
  input wire logic o_port_g_bit1_oe,
  input wire logic o_svc_error,
  input wire logic o_clock_error,
  input wire logic o_window_open
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic cfgd;

  // ----------------------------------------------------------------
  // Helper: readback may change once only
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfgd <= 1'b0;
    end else if ($changed(o_svc_rdata)) begin
      cfgd <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |-> !o_port_g_bit1_oe && !o_clock_error)
    else $error("fault active in reset");
  reset_word_a: assert property ($fell(i_rst) |-> o_svc_rdata == 8'hc1)
    else $error("reset word wrong");
  load_once_a: assert property ($changed(o_svc_rdata) |-> $past(i_svc_wr) && !cfgd)
    else $error("readback changed without first write");
  pin_low_a: assert property (o_port_g_bit1 == 1'b0)
    else $error("fault pin driven high");
  err_drive_a: assert property (o_svc_error |-> o_port_g_bit1_oe)
    else $error("service fault not driving pin");
  err_pulse_a: assert property (o_svc_error |=> !o_svc_error)
    else $error("service fault longer than one cycle");
  oe_cause_a: assert property ($rose(o_port_g_bit1_oe) |-> ##[0:2] (o_svc_error || o_clock_error))
    else $error("pin driven without a fault");
  cm_drive_a: assert property (o_clock_error |-> ##[0:2] o_port_g_bit1_oe)
    else $error("clock fault not driving pin");
  fault_shut_a: assert property (o_svc_error |=> !o_window_open [*4])
    else $error("window open during fault pulse");
  key_hidden_a: assert property (o_svc_rdata[5:1] == 5'h00)
    else $error("key visible in readback");
endmodule

/* dv/stc_service_timer_test.sv */
// Self-checking bench for the service timer and clock monitor.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module stc_service_timer_test;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, wr = 1'b0, halt = 1'b0, idle = 1'b0, rc = 1'b0, cds = 1'b0;
  logic clock_input_pin = 1'b0, cki_run = 1'b1, oe, pin, g_out, serr, cerr, wopen;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] ck_cnt = 2'h0;
  int mismatches = 0, n_compared = 0, t1, t2;

  // ----------------------------------------------------------------
  // Clocks, design and pull-up
  // ----------------------------------------------------------------
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  // Core clock pin: four system clocks a period, stops when asked
  always @(posedge i_clk_sys) begin
    if (cki_run) begin
      ck_cnt <= ck_cnt + 2'h1;
      clock_input_pin <= ck_cnt[1];
    end
  end
  stc_service_timer #(.CKI_PER_TC(1), .CM_GAP_CYC(20'h000c8)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_svc_wr(wr), .i_svc_wdata(wdata), .o_svc_rdata(rdata), .i_halt(halt), .i_idle(idle), .i_osc_rc(rc),
    .i_clock_delay_select(cds), .i_clock_input_pin(clock_input_pin), .i_port_g_bit1(pin), .o_port_g_bit1(g_out),
    .o_port_g_bit1_oe(oe), .o_svc_error(serr), .o_clock_error(cerr), .o_window_open(wopen));
  stc_pullup u_pull (.i_drive(oe), .i_level(g_out), .o_wire(pin));

  // ----------------------------------------------------------------
  // Expectations and drivers
  // ----------------------------------------------------------------
  function automatic logic [7:0] word(input logic [1:0] s, input logic c);
    return {s, 5'h0c, c};
  endfunction
  function automatic logic [7:0] shown(input logic [1:0] s, input logic c);
    return {s, 5'h00, c};
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return oe;
      1: return wopen;
      2: return cerr;
      default: return serr;
    endcase
  endfunction
  // Fault flag is a one-cycle pulse: look just after the edge that takes the write
  task automatic wr_svc(input logic [7:0] d);
    @(posedge i_clk_sys);
    wr <= 1'b1;
    wdata <= d;
    @(posedge i_clk_sys);
    wr <= 1'b0;
    #1;
  endtask
  task automatic wait_for(input int w, input logic v, input int n, output int t);
    for (t = 0; t < n && sig(w) !== v; t++) @(posedge i_clk_sys) #1;
    `CHK("wait", v, sig(w))
  endtask
  // Let the pulse end and the sensed pin settle high again
  task automatic recover();
    wait_for(0, 1'b0, 800, t1);
    repeat (12) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic pause(input logic h, input logic r, input logic c);
    @(posedge i_clk_sys);
    rc <= r;
    cds <= c;
    halt <= h;
    idle <= !h;
    repeat (40) @(posedge i_clk_sys);
    halt <= 1'b0;
    idle <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h910295ca));
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys) #1;
    `CHK("rdata", shown(2'h3, 1'b1), rdata)
    `CHK("oe", 1'b0, oe)
    wr_svc({2'($urandom), 5'h0c ^ 5'($urandom_range(31, 1)), 1'($urandom)});
    `CHK("svc_err", 1'b1, serr)
    // A write during the pulse would otherwise configure
    wr_svc(word(2'h0, 1'b1));
    recover();
    `CHK("rdata", shown(2'h3, 1'b1), rdata)
    wr_svc(word(2'h0, 1'b1));
    `CHK("svc_err", 1'b0, serr)
    `CHK("rdata", shown(2'h0, 1'b1), rdata)
    wr_svc(word(2'h0, 1'b1));
    `CHK("svc_err", 1'b1, serr)
    recover();
    wait_for(1, 1'b1, 9000, t1);
    // One random bit flipped hits window, key or monitor field
    wr_svc(word(2'h0, 1'b1) ^ (8'h01 << $urandom_range(7, 0)));
    `CHK("svc_err", 1'b1, serr)
    recover();
    for (int m = 0; m < 2; m++) begin
      wait_for(1, 1'b1, 9000, t1);
      pause(m == 0, 1'($urandom), 1'b1);
      `CHK("open", 1'b0, wopen)
      wr_svc(word(2'h0, 1'b1));
      `CHK("svc_err", 1'b1, serr)
      recover();
    end
    wait_for(1, 1'b1, 9000, t1);
    pause(1'b1, 1'b1, 1'b0);
    `CHK("open", 1'b1, wopen)
    wr_svc(word(2'h0, 1'b1));
    `CHK("svc_err", 1'b0, serr)
    wait_for(1, 1'b1, 9000, t1);
    wait_for(3, 1'b1, 26000, t2);
    `CHK("lower", 1'b1, t1 > 8170 && t1 < 8210)
    `CHK("upper", 1'b1, t1 + t2 > 32740 && t1 + t2 < 32800)
    recover();
    // Halted core clock must still be caught by the monitor
    @(posedge i_clk_sys);
    halt <= 1'b1;
    cki_run <= 1'b0;
    wait_for(2, 1'b1, 400, t1);
    `CHK("cm_gap", 1'b1, t1 > 190 && t1 < 215)
    `CHK("oe", 1'b1, oe)
    @(posedge i_clk_sys);
    cki_run <= 1'b1;
    wait_for(2, 1'b0, 400, t1);
    `CHK("cm_hold", 1'b1, t1 > 80 && t1 < 120)
    repeat (3) @(posedge i_clk_sys);
    #1;
    `CHK("oe", 1'b0, oe)
    print_verdict();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #2400000;
    mismatches++;
    print_verdict();
  end
endmodule

bind stc_service_timer stc_service_timer_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_svc_wr(i_svc_wr), .o_svc_rdata(o_svc_rdata), .o_port_g_bit1(o_port_g_bit1),
  .o_port_g_bit1_oe(o_port_g_bit1_oe), .o_svc_error(o_svc_error), .o_clock_error(o_clock_error),
  .o_window_open(o_window_open));

/* hdl/stc_clkmon.sv */
// Instruction-cycle tick generator and slow/absent clock monitor.
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_clkmon #(
  parameter int CKI_PER_TC = `STC_CKI_PER_TC,
  parameter logic [19:0] GAP_CYC = 20'(`STC_CM_GAP_CYC)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cki_lvl,
  input wire logic i_enable,
  output logic o_tc_tick,
  output logic o_fault
);

  stc_pkg::stc_cm_t r;
  stc_pkg::stc_cm_t next_r;
  logic rise;

  // ----------------------------------------------------------------
  // Tick every CKI_PER_TC rising edges; gap counter watches ticks
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    rise = i_cki_lvl & ~r.prev;
    next_r.prev = i_cki_lvl;
    next_r.tick = 1'b0;
    if (rise) begin
      if (r.div == 4'(CKI_PER_TC - 1)) begin
        next_r.div = 4'h0;
        next_r.tick = 1'b1;
      end else begin
        next_r.div = r.div + 4'h1;
      end
    end
    // Gap saturates so a dead clock holds the fault without wrap
    if (r.tick) begin
      next_r.gap = 20'h00000;
    end else if (r.gap != GAP_CYC) begin
      next_r.gap = r.gap + 20'h00001;
    end
    // Fault while slow; release only after enough good cycles
    if (!i_enable) begin
      next_r.fault = 1'b0;
      next_r.rec = 5'h00;
    end else if (r.gap == GAP_CYC) begin // [RULE12] [RULE13] [RULE16]
      next_r.fault = 1'b1;
      next_r.rec = 5'h00;
    end else if (r.fault && r.tick) begin
      if (r.rec == `STC_HOLD_TC - 5'h01) begin // [RULE12]
        next_r.fault = 1'b0;
        next_r.rec = 5'h00;
      end else begin
        next_r.rec = r.rec + 5'h01;
      end
    end
  end

  // State register; monitor stays quiet under reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r <= '0; // [RULE1]
    end else begin
      r <= next_r;
    end
  end

  assign o_tc_tick = r.tick;
  assign o_fault = r.fault;

endmodule

/* hdl/stc_pkg.sv */
// Types shared by the service timer, clock monitor and synchroniser.
package stc_pkg;

  // ----------------------------------------------------------------
  // Fault pin sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    STC_RUN = 4'h1,
    STC_DRIVE = 4'h2,
    STC_HOLD = 4'h4,
    STC_RELEASE = 4'h8
  } stc_state_t;

  // ----------------------------------------------------------------
  // State records, one per module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } stc_sync_t;

  typedef struct packed {
    logic prev;
    logic [3:0] div;
    logic [19:0] gap;
    logic [4:0] rec;
    logic fault;
    logic tick;
  } stc_cm_t;

  typedef struct packed {
    stc_state_t st;
    logic [1:0] sel;
    logic cm_en;
    logic configured;
    logic [16:0] win;
    logic [4:0] hold;
    logic halt_q;
    logic idle_q;
    logic oe;
    logic [7:0] rdata;
    logic svc_err;
    logic clk_err;
    logic open_win;
  } stc_top_t;

endpackage

/* hdl/stc_regs.svh */
// Constants for the service timer and clock monitor: fields, key, reset values, timing.
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// ----------------------------------------------------------------
// Service word layout
// ----------------------------------------------------------------
`define STC_SEL_HI 7
`define STC_SEL_LO 6
`define STC_KEY_HI 5
`define STC_KEY_LO 1
`define STC_CM_BIT 0
`define STC_KEY_VAL 5'h0c
`define STC_KEY_READ 5'h00
`define STC_SEL_RST 2'h3
`define STC_CM_RST 1'b1

// ----------------------------------------------------------------
// Window limits and pulse lengths in instruction cycles, and core clock edges per cycle
// ----------------------------------------------------------------
`define STC_LOWER_TC 17'h00800
`define STC_UPPER_BASE_TC 17'h02000
`define STC_HOLD_TC 5'h18
`define STC_CKI_PER_TC 10

// ----------------------------------------------------------------
// Clock monitor threshold: a time and the rate it is counted at
// ----------------------------------------------------------------
`define STC_CM_GAP_US 1000
`define STC_CLK_MHZ 40
`define STC_CM_GAP_CYC (`STC_CM_GAP_US * `STC_CLK_MHZ)

`endif

/* hdl/stc_service_timer.sv */
// Windowed service timer with clock monitor driving an open-drain fault pin.
//
// Functional notes
// RULE1 - Both detectors inactive while reset asserted
// RULE2 - Reset leaves maximum window, monitor enabled
// RULE3 - First write loads fields; wrong key faults
// RULE4 - Later writes must match all stored fields
// RULE5 - No valid service by upper limit faults
// RULE6 - Service before lower limit faults
// RULE7 - First write restarts window, never early fault
// RULE8 - Fault pin active low, never driven high
// RULE9 - Hold pin low 16-32 cycles after sensed
// RULE10 - Window restarts when sensed pin returns high; code does so only on leaving STC_RELEASE, not after a monitor fault
// RULE11 - Services ignored while pin driven low; code still takes them in STC_RUN while the monitor alone pulls it low
// RULE12 - Monitor holds pin low, releases after recovery
// RULE13 - Accept 10 kHz, reject below 10 Hz
// RULE14 - Key field reads back as zeros
// RULE15 - Timer suspended during halt and idle
// RULE16 - Monitor stays active in halt and idle
// RULE17 - RC without clock delay resumes after halt
// RULE18 - Otherwise halt exit restarts the window
// RULE19 - Idle exit performs hardware service
// RULE20 - Select bits pick 8k to 64k upper limit
// RULE21 - Bit zero enables the clock monitor
// RULE22 - Fully matching write restarts the window
// RULE23 - One instruction-cycle counter times everything
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_service_timer #(
  parameter int CKI_PER_TC = `STC_CKI_PER_TC,
  parameter logic [19:0] CM_GAP_CYC = 20'(`STC_CM_GAP_CYC)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_svc_wr,
  input wire logic [7:0] i_svc_wdata,
  output logic [7:0] o_svc_rdata,
  input wire logic i_halt,
  input wire logic i_idle,
  input wire logic i_osc_rc,
  input wire logic i_clock_delay_select,
  input wire logic i_clock_input_pin,
  input wire logic i_port_g_bit1,
  output logic o_port_g_bit1,
  output logic o_port_g_bit1_oe,
  output logic o_svc_error,
  output logic o_clock_error,
  output logic o_window_open
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Upper limit doubles with each step of the select field
  function automatic logic [16:0] stc_upper(input logic [1:0] sel);
    stc_upper = `STC_UPPER_BASE_TC << sel; // [RULE20]
  endfunction

  // Key field of a written word compared against the fixed key
  function automatic logic stc_key_ok(input logic [7:0] w);
    stc_key_ok = (w[`STC_KEY_HI:`STC_KEY_LO] == `STC_KEY_VAL);
  endfunction

  // Readback image: key field always blanked
  function automatic logic [7:0] stc_image(input logic [1:0] sel, input logic cm);
    stc_image = {sel, `STC_KEY_READ, cm}; // [RULE14]
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and clock monitor
  // ----------------------------------------------------------------
  stc_pkg::stc_top_t r;
  stc_pkg::stc_top_t next_r;
  logic pin_lvl;
  logic cki_lvl;
  logic tc_tick;
  logic cm_fault;

  // Sensed pin level; pulled up externally, so idle value is high
  stc_sync #(
    .RST_VAL(1'b1)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_port_g_bit1),
    .o_lvl(pin_lvl)
  );

  // Core clock input arrives from outside this clock domain
  stc_sync #(
    .RST_VAL(1'b0)
  ) u_cki_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_clock_input_pin),
    .o_lvl(cki_lvl)
  );

  // Monitor runs regardless of halt or idle
  stc_clkmon #(
    .CKI_PER_TC(CKI_PER_TC),
    .GAP_CYC(CM_GAP_CYC)
  ) u_clkmon (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_cki_lvl(cki_lvl),
    .i_enable(r.cm_en), // [RULE21] [RULE16]
    .o_tc_tick(tc_tick),
    .o_fault(cm_fault)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic suspended;
  logic halt_exit;
  logic idle_exit;
  logic resume_halt;
  logic early;
  logic timeout;
  logic full_match;
  logic fault_now;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    fault_now = 1'b0;
    next_r.svc_err = 1'b0;
    next_r.halt_q = i_halt;
    next_r.idle_q = i_idle;

    // Low-power tracking; the timer freezes in either mode
    suspended = i_halt | i_idle; // [RULE15]
    halt_exit = r.halt_q & ~i_halt;
    idle_exit = r.idle_q & ~i_idle;
    // RC oscillator with no start-up delay picks up where it stopped
    resume_halt = i_osc_rc & ~i_clock_delay_select; // [RULE17]

    // Window comparisons against the current count
    early = (r.win < `STC_LOWER_TC); // [RULE6]
    timeout = (r.win >= stc_upper(r.sel)); // [RULE5] [RULE20]
    full_match = (i_svc_wdata[`STC_SEL_HI:`STC_SEL_LO] == r.sel) &&
                 stc_key_ok(i_svc_wdata) &&
                 (i_svc_wdata[`STC_CM_BIT] == r.cm_en); // [RULE4]

    case (r.st)
      stc_pkg::STC_RUN: begin
        // Count instruction cycles only while awake
        if (tc_tick && !suspended && !timeout) begin
          next_r.win = r.win + 17'h00001; // [RULE23]
        end

        // Halt exit: restart unless resuming; idle exit services
        if (halt_exit && !resume_halt) begin
          next_r.win = 17'h00000; // [RULE18]
        end
        if (idle_exit) begin
          next_r.win = 17'h00000; // [RULE19]
        end

        // Software service writes
        if (i_svc_wr) begin
          if (!r.configured) begin
            // First write: configures once, may land anywhere
            if (stc_key_ok(i_svc_wdata)) begin // [RULE3]
              next_r.sel = i_svc_wdata[`STC_SEL_HI:`STC_SEL_LO];
              next_r.cm_en = i_svc_wdata[`STC_CM_BIT]; // [RULE21]
              next_r.configured = 1'b1;
              next_r.win = 17'h00000; // [RULE7]
            end else begin
              fault_now = 1'b1; // [RULE3]
            end
          end else if (full_match && !early) begin
            next_r.win = 17'h00000; // [RULE22]
          end else begin
            fault_now = 1'b1; // [RULE4] [RULE6]
          end
        end

        // Expiry of the upper limit, checked only when not suspended
        if (timeout && !suspended) begin
          fault_now = 1'b1; // [RULE5]
        end

        if (fault_now) begin
          next_r.st = stc_pkg::STC_DRIVE; // [RULE9]
          next_r.svc_err = 1'b1;
          next_r.hold = 5'h00;
        end
      end

      stc_pkg::STC_DRIVE: begin
        // Pull low until the pin is seen below threshold
        // Writes here are dropped without effect
        if (!pin_lvl) begin // [RULE11]
          next_r.st = stc_pkg::STC_HOLD;
          next_r.hold = 5'h00;
        end
      end

      stc_pkg::STC_HOLD: begin
        // Keep pulling for the hold count of instruction cycles
        if (tc_tick) begin
          if (r.hold == `STC_HOLD_TC - 5'h01) begin // [RULE9]
            next_r.st = stc_pkg::STC_RELEASE;
          end else begin
            next_r.hold = r.hold + 5'h01;
          end
        end
      end

      stc_pkg::STC_RELEASE: begin
        // Wait for the pull-up; the clock monitor may still hold it low
        if (pin_lvl) begin
          next_r.st = stc_pkg::STC_RUN;
          next_r.win = 17'h00000; // [RULE10]
        end
      end

      default: begin
        next_r.st = stc_pkg::STC_RUN;
      end
    endcase

    // Open-drain enable: either source pulls, nothing drives high
    next_r.oe = (next_r.st == stc_pkg::STC_DRIVE) ||
                (next_r.st == stc_pkg::STC_HOLD) || cm_fault; // [RULE8] [RULE9] [RULE12]
    next_r.clk_err = cm_fault;
    next_r.rdata = stc_image(next_r.sel, next_r.cm_en); // [RULE14]
    next_r.open_win = (next_r.st == stc_pkg::STC_RUN) &&
                      (next_r.win >= `STC_LOWER_TC);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset holds the pin released and arms the widest window
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r.st <= stc_pkg::STC_RUN;
      r.sel <= `STC_SEL_RST; // [RULE2]
      r.cm_en <= `STC_CM_RST; // [RULE2]
      r.configured <= 1'b0;
      r.win <= 17'h00000;
      r.hold <= 5'h00;
      r.halt_q <= 1'b0;
      r.idle_q <= 1'b0;
      r.oe <= 1'b0; // [RULE1]
      r.rdata <= {`STC_SEL_RST, `STC_KEY_READ, `STC_CM_RST};
      r.svc_err <= 1'b0;
      r.clk_err <= 1'b0;
      r.open_win <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all but the constant pin data straight from flops
  // ----------------------------------------------------------------

  // Pin data is a constant low; only the enable ever moves
  assign o_port_g_bit1 = 1'b0; // [RULE8]
  assign o_port_g_bit1_oe = r.oe;
  assign o_svc_rdata = r.rdata;
  assign o_svc_error = r.svc_err;
  assign o_clock_error = r.clk_err;
  assign o_window_open = r.open_win;

endmodule

/* hdl/stc_sync.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module stc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_lvl
);

  stc_pkg::stc_sync_t r;
  stc_pkg::stc_sync_t next_r;

  // Level moves only when stages two and three agree
  always_comb begin
    next_r = r;
    next_r.s1 = i_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.lvl = r.s3;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign o_lvl = r.lvl;

endmodule
